// ### shared/ssar_pkg.sv
// Shared constants, types and helpers of the stereo serial audio link
`default_nettype none
package ssar_pkg;
    // Framing formats
    typedef enum logic [1:0] {
        SSAR_FMT_I2S,
        SSAR_FMT_LEFT,
        SSAR_FMT_RIGHT
    } ssar_fmt_t;

    // Slot length selection: 32, 48 or 64 bit clocks per sample period
    localparam logic [1:0] SLOT_SEL_16 = 2'h0;
    localparam logic [1:0] SLOT_SEL_24 = 2'h1;
    localparam logic [1:0] SLOT_SEL_32 = 2'h2;
    localparam logic [5:0] SLOT_LEN_16 = 6'h10;
    localparam logic [5:0] SLOT_LEN_24 = 6'h18;
    localparam logic [5:0] SLOT_LEN_32 = 6'h20;

    // Word widths accepted and delivered
    localparam int OUT_W = 24;
    localparam logic [5:0] WORD_MIN = 6'h10;
    localparam logic [5:0] WORD_MAX = 6'h18;
    localparam logic [5:0] CNT_SAT = 6'h3F;

    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int BCLK_PERIOD_NS = 160;
    localparam int BCLK_HALF_CYC = BCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int SS_MIN_FRAME_NS = 20000;
    localparam int SS_MIN_FRAME_CYC = (SS_MIN_FRAME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Reset values
    localparam logic [5:0] POS_RST = 6'h00;
    localparam logic [OUT_W-1:0] WORD_RST = 24'h000000;

    // Slot length in bit clocks for a selection code
    function automatic logic [5:0] ssar_slot_len(input logic [1:0] sel);
        case (sel)
            SLOT_SEL_16: return SLOT_LEN_16;
            SLOT_SEL_24: return SLOT_LEN_24;
            default: return SLOT_LEN_32;
        endcase
    endfunction
endpackage
`default_nettype wire

// ### shared/ssar_link_if.sv
// Serial audio link wires between the source and the receiver
`timescale 1ns/1ns
`default_nettype none
interface ssar_link_if;
    logic bit_clk;
    logic frame_select;
    logic serial_data;

    // Source drives every wire
    modport src (
        output bit_clk,
        output frame_select,
        output serial_data
    );

    // Receiver only listens
    modport rcv (
        input bit_clk,
        input frame_select,
        input serial_data
    );
endinterface
`default_nettype wire

// ### hw/ssar_src.sv
// Audio source end: bit clock divider and framed serial transmitter
`timescale 1ns/1ns
`default_nettype none
module ssar_src
    import ssar_pkg::*;
#(
    parameter int HALF_CYC = BCLK_HALF_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    ssar_link_if.src link,
    input wire logic [1:0] cfg_format,
    input wire logic [1:0] cfg_slot_sel,
    input wire logic [5:0] cfg_word_len,
    input wire logic pair_valid,
    output logic pair_ready,
    input wire logic [OUT_W-1:0] pair_left,
    input wire logic [OUT_W-1:0] pair_right
);
    logic [15:0] div_ff;
    logic bclk_ff;
    logic fs_ff;
    logic sd_ff;
    logic [5:0] pos_ff;
    logic hold_v_ff;
    logic [OUT_W-1:0] hold_l_ff;
    logic [OUT_W-1:0] hold_r_ff;
    logic [OUT_W-1:0] cur_l_ff;
    logic [OUT_W-1:0] cur_r_ff;
    logic [OUT_W-1:0] stage_r_ff;
    logic tick;
    logic fall;
    logic is_i2s;
    logic is_rj;
    logic [5:0] slot;
    logic [5:0] last_pos;
    logic nxt_fs;
    logic nxt_sd;

    assign tick = (div_ff == 16'(HALF_CYC - 1));
    assign fall = tick & bclk_ff;
    assign is_i2s = (cfg_format == SSAR_FMT_I2S);
    assign is_rj = (cfg_format == SSAR_FMT_RIGHT);
    assign slot = ssar_slot_len(cfg_slot_sel);
    assign last_pos = 6'((slot << 1) - 6'h01);
    assign pair_ready = ~hold_v_ff;
    assign link.bit_clk = bclk_ff;
    assign link.frame_select = fs_ff;
    assign link.serial_data = sd_ff;

    // Bit clock made from the system clock by a divider
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_ff <= 16'h0000;
            bclk_ff <= 1'b0;
        end else if (tick) begin
            div_ff <= 16'h0000;
            bclk_ff <= ~bclk_ff;
        end else begin
            div_ff <= div_ff + 16'h0001;
        end
    end

    // Frame select and data bit for the current frame position
    always_comb begin
        logic [5:0] d;
        logic [5:0] q;
        logic [5:0] k;
        logic right;
        logic ok;
        logic [OUT_W-1:0] w;
        d = is_i2s ? ((pos_ff == POS_RST) ? last_pos : pos_ff - 6'h01) : pos_ff;
        right = (d >= slot);
        q = right ? d - slot : d;
        ok = 1'b1;
        k = q;
        if (is_rj) begin
            ok = (q >= slot - cfg_word_len);
            k = q - (slot - cfg_word_len);
        end
        w = right ? cur_r_ff : cur_l_ff;
        nxt_sd = ok && (k < cfg_word_len) && w[5'(23 - k)];
        nxt_fs = is_i2s ? (pos_ff >= slot) : (pos_ff < slot);
    end

    // Outputs change on the falling bit clock so they are stable at the rise
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pos_ff <= POS_RST;
            fs_ff <= 1'b0;
            sd_ff <= 1'b0;
        end else if (fall) begin
            fs_ff <= nxt_fs;
            sd_ff <= nxt_sd;
            pos_ff <= (pos_ff >= last_pos) ? POS_RST : pos_ff + 6'h01;
        end
    end

    // Pair hold register and per-channel word loading
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hold_v_ff <= 1'b0;
            hold_l_ff <= WORD_RST;
            hold_r_ff <= WORD_RST;
            cur_l_ff <= WORD_RST;
            cur_r_ff <= WORD_RST;
            stage_r_ff <= WORD_RST;
        end else begin
            if (pair_valid && pair_ready) begin
                hold_l_ff <= pair_left;
                hold_r_ff <= pair_right;
            end
            if (fall && pos_ff >= last_pos) begin
                cur_l_ff <= hold_v_ff ? hold_l_ff : WORD_RST;
                stage_r_ff <= hold_v_ff ? hold_r_ff : WORD_RST;
            end
            if (fall && pos_ff == (is_i2s ? slot : slot - 6'h01)) begin
                cur_r_ff <= stage_r_ff;
            end
            if (pair_valid && pair_ready) begin
                hold_v_ff <= 1'b1;
            end else if (fall && pos_ff >= last_pos) begin
                hold_v_ff <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ### hw/ssar_rcv.sv
// Receiver end: serial audio decoder delivering stereo pairs
// Functional notes
// - Software mode adds left and right aligned framing
// - Hardware mode: I2S only, 32/48/64 ratios
// - Double speed only in software mode
// - I2S: frame select low left, high right
// - Source clocks 32/48/64 bits per sample
// - I2S: MSB one bit after select change
// - MSB first two's complement, rising edge capture
// - Left aligned: frame select high means left
// - Left aligned: MSB with the select change
// - Left aligned: MSB first, rising edge capture
// - Accept 16 to 24 bits, zero trailing bits
// - Stereo bridged or paralleled mono output selectable
// - Shutdown, fault, soft clip pins work in software
// - Hardware mode settings come from static pins
// - Right aligned: LSB last, leading bits zero
`timescale 1ns/1ns
`default_nettype none
module ssar_rcv
    import ssar_pkg::*;
#(
    parameter int DEPTH = 2,
    parameter int MIN_FRAME_CYC = SS_MIN_FRAME_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    ssar_link_if.rcv link,
    input wire logic hw_mode,
    input wire logic hw_mono_sel,
    input wire logic [1:0] cfg_format,
    input wire logic cfg_double_speed,
    input wire logic [5:0] cfg_word_len,
    input wire logic cfg_mono,
    input wire logic amp_shutdown_n,
    input wire logic soft_clip_select,
    output logic amp_fault_n,
    output logic clip_enable,
    output logic mono_active,
    output logic double_speed_active,
    output logic overrun,
    output logic pair_valid,
    input wire logic pair_ready,
    output logic [OUT_W-1:0] pair_left,
    output logic [OUT_W-1:0] pair_right
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int PW = 2 * OUT_W;

    // Pin synchroniser bits
    localparam int P_BCLK = 0;
    localparam int P_FS = 1;
    localparam int P_SD = 2;
    localparam int P_SDN = 3;
    localparam int P_CLIP = 4;
    localparam int P_HW = 5;
    localparam int P_MONO = 6;

    logic [6:0] pin_s1_ff;
    logic [6:0] pin_s2_ff;
    logic bclk_s3_ff;
    logic fs_prev_ff;
    logic chan_ff;
    logic chan_ok_ff;
    logic started_ff;
    logic frame_seen_ff;
    logic got_left_ff;
    logic fault_ff;
    logic overrun_ff;
    logic clip_ff;
    logic mono_ff;
    logic dbl_ff;
    logic [31:0] sh_ff;
    logic [5:0] cnt_ff;
    logic [15:0] frm_ff;
    logic [OUT_W-1:0] left_ff;
    logic [PW-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0] count_ff;

    logic [6:0] pins;
    logic bclk_rise;
    logic run;
    logic hw;
    logic [1:0] fmt_eff;
    logic dbl_eff;
    logic mono_eff;
    logic [5:0] len_eff;
    logic is_right;
    logic boundary;
    logic slot_ok;
    logic slot_err;
    logic rate_err;
    logic [OUT_W-1:0] word;
    logic [OUT_W:0] sum;
    logic push_req;
    logic in_ready;
    logic push;
    logic pop;

    // Align a finished slot to the 24 bit output word
    function automatic logic [OUT_W-1:0] ssar_align(input logic [31:0] sh, input logic [5:0] cnt,
                                                    input logic [5:0] len, input logic rj);
        logic [31:0] w;
        logic [OUT_W-1:0] keep;
        keep = ~(24'hFFFFFF >> len);
        if (rj) begin
            w = (sh & ~(32'hFFFFFFFF << len)) << (WORD_MAX - len);
        end else if (cnt >= WORD_MAX) begin
            w = sh >> (cnt - WORD_MAX);
        end else begin
            w = sh << (WORD_MAX - cnt);
        end
        return w[OUT_W-1:0] & keep;
    endfunction

    assign pins = {hw_mono_sel, hw_mode, soft_clip_select, amp_shutdown_n,
                   link.serial_data, link.frame_select, link.bit_clk};

    // Two-stage synchroniser on every pin, plus bit clock edge stage
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_s1_ff <= 7'h00;
            pin_s2_ff <= 7'h00;
            bclk_s3_ff <= 1'b0;
        end else begin
            pin_s1_ff <= pins;
            pin_s2_ff <= pin_s1_ff;
            bclk_s3_ff <= pin_s2_ff[P_BCLK];
        end
    end

    // Effective settings: hardware mode overrides configuration
    assign bclk_rise = pin_s2_ff[P_BCLK] & ~bclk_s3_ff;
    assign run = pin_s2_ff[P_SDN];
    assign hw = pin_s2_ff[P_HW];
    assign fmt_eff = hw ? SSAR_FMT_I2S : cfg_format;
    assign dbl_eff = hw ? 1'b0 : cfg_double_speed;
    assign mono_eff = hw ? pin_s2_ff[P_MONO] : cfg_mono;
    assign len_eff = hw ? WORD_MAX : (cfg_word_len < WORD_MIN) ? WORD_MIN :
                     (cfg_word_len > WORD_MAX) ? WORD_MAX : cfg_word_len;

    // I2S slots start one bit late, so it uses the select seen one edge back
    assign is_right = (fmt_eff == SSAR_FMT_I2S) ? fs_prev_ff : ~pin_s2_ff[P_FS];
    // The first rise only loads the channel, so a reset level cannot fake a short slot
    assign boundary = bclk_rise & chan_ok_ff & (is_right != chan_ff);
    assign slot_ok = (cnt_ff == SLOT_LEN_16) || (cnt_ff == SLOT_LEN_24) ||
                     (cnt_ff == SLOT_LEN_32);
    assign slot_err = boundary & started_ff & ~slot_ok;
    assign rate_err = boundary & ~is_right & frame_seen_ff & ~dbl_eff &
                      (frm_ff < 16'(MIN_FRAME_CYC));
    assign word = ssar_align(sh_ff, cnt_ff, len_eff, fmt_eff == SSAR_FMT_RIGHT);
    assign sum = {left_ff[OUT_W-1], left_ff} + {word[OUT_W-1], word};

    // Bit capture, MSB first, on each rising bit clock
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fs_prev_ff <= 1'b0;
            chan_ff <= 1'b0;
            chan_ok_ff <= 1'b0;
            sh_ff <= 32'h00000000;
            cnt_ff <= 6'h00;
        end else if (bclk_rise) begin
            fs_prev_ff <= pin_s2_ff[P_FS];
            chan_ff <= is_right;
            chan_ok_ff <= 1'b1;
            if (boundary) begin
                sh_ff <= {31'h00000000, pin_s2_ff[P_SD]};
                cnt_ff <= 6'h01;
            end else begin
                sh_ff <= {sh_ff[30:0], pin_s2_ff[P_SD]};
                cnt_ff <= (cnt_ff == CNT_SAT) ? cnt_ff : cnt_ff + 6'h01;
            end
        end
    end

    // Frame tracking, left word holding and frame period count
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            started_ff <= 1'b0;
            frame_seen_ff <= 1'b0;
            got_left_ff <= 1'b0;
            left_ff <= WORD_RST;
            frm_ff <= 16'h0000;
        end else if (!run) begin
            started_ff <= 1'b0;
            frame_seen_ff <= 1'b0;
            got_left_ff <= 1'b0;
            frm_ff <= 16'h0000;
        end else begin
            frm_ff <= (boundary && !is_right) ? 16'h0000 :
                      (frm_ff == 16'hFFFF) ? frm_ff : frm_ff + 16'h0001;
            if (boundary) begin
                started_ff <= 1'b1;
                if (!is_right && started_ff) begin
                    frame_seen_ff <= 1'b1;
                end
                if (!chan_ff && started_ff) begin
                    left_ff <= word;
                    got_left_ff <= slot_ok;
                end else if (chan_ff) begin
                    got_left_ff <= 1'b0;
                end
            end
        end
    end

    // Fault latch: set wins, cleared only while shutdown is held low
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fault_ff <= 1'b0;
            overrun_ff <= 1'b0;
        end else begin
            fault_ff <= (slot_err | rate_err) ? 1'b1 : (run ? fault_ff : 1'b0);
            overrun_ff <= (push_req & ~in_ready) ? 1'b1 : (run ? overrun_ff : 1'b0);
        end
    end

    // Status pins stay live in both control modes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            clip_ff <= 1'b0;
            mono_ff <= 1'b0;
            dbl_ff <= 1'b0;
        end else begin
            clip_ff <= pin_s2_ff[P_CLIP];
            mono_ff <= mono_eff;
            dbl_ff <= dbl_eff;
        end
    end

    assign amp_fault_n = ~fault_ff;
    assign clip_enable = clip_ff;
    assign mono_active = mono_ff;
    assign double_speed_active = dbl_ff;
    assign overrun = overrun_ff;

    // Completed right slot closes the frame and yields one pair
    assign push_req = boundary & chan_ff & got_left_ff & slot_ok & run & ~fault_ff;
    assign in_ready = (count_ff < (AW+1)'(DEPTH));
    assign push = push_req & in_ready;
    assign pop = pair_valid & pair_ready;

    // Pair buffer between decoder and audio path
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_ff[i] <= {PW{1'b0}};
            end
            wr_ff <= '0;
            rd_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                mem_ff[wr_ff] <= mono_eff ? {sum[OUT_W:1], sum[OUT_W:1]} : {left_ff, word};
                wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + AW'(1);
            end
            if (pop) begin
                rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + AW'(1);
            end
            count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    assign pair_valid = (count_ff != '0);
    assign pair_left = mem_ff[rd_ff][PW-1:OUT_W];
    assign pair_right = mem_ff[rd_ff][OUT_W-1:0];
endmodule
`default_nettype wire

// ### verif/ssar_link_sva.sv
// Protocol checker for the serial audio link wires
`timescale 1ns/1ns
`default_nettype none
module ssar_link_sva #(
    parameter int HALF_CYC = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic bit_clk,
    input wire logic frame_select,
    input wire logic serial_data,
    input wire logic [1:0] cfg_format,
    input wire logic [1:0] cfg_slot_sel,
    input wire logic [5:0] cfg_word_len
);
    logic bclk_q_ff;
    logic fs_q_ff;
    logic ph_ok_ff;
    logic [7:0] ph_cnt_ff;
    logic [6:0] fall_cnt_ff;
    logic [6:0] last_len_ff;
    logic [1:0] slots_ff;
    logic fall_w;
    logic fs_chg_w;
    logic [6:0] slot_w;
    logic [6:0] len_w;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // Edge detects and the configured slot and word lengths
    assign fall_w = bclk_q_ff && !bit_clk;
    assign fs_chg_w = fs_q_ff != frame_select;
    assign slot_w = (cfg_slot_sel == 2'h0) ? 7'h10 : (cfg_slot_sel == 2'h1) ? 7'h18 : 7'h20;
    assign len_w = {1'b0, cfg_word_len};

    // Previous link levels
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bclk_q_ff <= 1'b0;
            fs_q_ff <= 1'b0;
        end else begin
            bclk_q_ff <= bit_clk;
            fs_q_ff <= frame_select;
        end
    end

    // Cycles spent in the present bit clock phase
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ph_cnt_ff <= 8'h00;
            ph_ok_ff <= 1'b0;
        end else if (bclk_q_ff != bit_clk) begin
            ph_cnt_ff <= 8'h00;
            ph_ok_ff <= 1'b1;
        end else begin
            ph_cnt_ff <= ph_cnt_ff + 8'h01;
        end
    end

    // Bit clocks per slot; the first slot after reset is partial
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fall_cnt_ff <= 7'h00;
            last_len_ff <= 7'h00;
            slots_ff <= 2'h0;
        end else if (fs_chg_w) begin
            fall_cnt_ff <= 7'h01;
            last_len_ff <= fall_cnt_ff;
            slots_ff <= (slots_ff == 2'h3) ? slots_ff : slots_ff + 2'h1;
        end else if (fall_w) begin
            fall_cnt_ff <= fall_cnt_ff + 7'h01;
        end
    end

    property p_fs_on_fall;
        fs_chg_w |-> fall_w;
    endproperty
    a_fs_on_fall: assert property (p_fs_on_fall)
        else $error("frame select moved away from a falling bit clock");

    property p_sd_on_fall;
        $changed(serial_data) |-> fall_w;
    endproperty
    a_sd_on_fall: assert property (p_sd_on_fall)
        else $error("serial data moved away from a falling bit clock");

    property p_half;
        (bclk_q_ff != bit_clk) && ph_ok_ff |-> ph_cnt_ff == 8'(HALF_CYC - 1);
    endproperty
    a_half: assert property (p_half)
        else $error("bit clock phase length wrong");

    property p_slot_len;
        fs_chg_w && slots_ff != 2'h0 |-> fall_cnt_ff inside {7'h10, 7'h18, 7'h20};
    endproperty
    a_slot_len: assert property (p_slot_len)
        else $error("slot is not 16, 24 or 32 bit clocks");

    property p_slot_pair;
        fs_chg_w && slots_ff[1] |-> fall_cnt_ff == last_len_ff;
    endproperty
    a_slot_pair: assert property (p_slot_pair)
        else $error("left and right slots differ in length");

    property p_fs_hold;
        fs_chg_w |=> $stable(frame_select) [*8];
    endproperty
    a_fs_hold: assert property (p_fs_hold)
        else $error("frame select glitched after a change");

    property p_lj_pad;
        fall_w && !fs_chg_w && slots_ff != 2'h0 && cfg_format == 2'h1
            && fall_cnt_ff >= len_w |-> !serial_data;
    endproperty
    a_lj_pad: assert property (p_lj_pad)
        else $error("trailing bit not zero in left aligned slot");

    property p_rj_pad;
        fall_w && !fs_chg_w && slots_ff != 2'h0 && cfg_format == 2'h2
            && fall_cnt_ff + len_w < slot_w |-> !serial_data;
    endproperty
    a_rj_pad: assert property (p_rj_pad)
        else $error("leading bit not zero in right aligned slot");

    c_pair: cover property (fs_chg_w && slots_ff[1]);
    c_lj: cover property (fall_w && cfg_format == 2'h1 && fall_cnt_ff >= len_w);
    c_rj: cover property (fall_w && cfg_format == 2'h2 && fall_cnt_ff + len_w < slot_w);
endmodule
`default_nettype wire

// ### verif/ssar_tb.sv
// Self-checking bench: source and receiver joined over the serial link
`timescale 1ns/1ns
`default_nettype none
module ssar_tb
    import ssar_pkg::*;
;
    logic clk, nrst, hw_mode, hw_mono_sel, cfg_double_speed, cfg_mono;
    logic amp_shutdown_n, soft_clip_select, stall_all;
    logic [1:0] src_format, rcv_format, cfg_slot_sel;
    logic [5:0] src_len, rcv_len;
    logic src_valid, src_ready, rcv_valid, rcv_ready;
    logic [OUT_W-1:0] src_left, src_right, rcv_left, rcv_right;
    logic amp_fault_n, clip_enable, mono_active, double_speed_active, overrun;
    integer seed, errors, num_checks;
    logic [OUT_W-1:0] exp_l[$];
    logic [OUT_W-1:0] exp_r[$];
    // Cases: hw mode, source format, receiver format, slot code, length, mono, double speed
    int tbl[6][7] = '{'{0, 0, 0, 0, 16, 0, 0}, '{0, 1, 1, 1, 20, 0, 1}, '{0, 2, 2, 2, 24, 1, 0},
        '{0, 2, 2, 2, 18, 0, 1}, '{1, 0, 1, 1, 24, 1, 1}, '{0, 1, 1, 2, 16, 1, 0}};

    ssar_link_if link_if();

    ssar_src #(.HALF_CYC(BCLK_HALF_CYC)) i_ssar_src (.clk(clk), .nrst(nrst), .link(link_if.src),
        .cfg_format(src_format), .cfg_slot_sel(cfg_slot_sel), .cfg_word_len(src_len),
        .pair_valid(src_valid), .pair_ready(src_ready), .pair_left(src_left),
        .pair_right(src_right));

    ssar_rcv #(.DEPTH(2), .MIN_FRAME_CYC(100)) i_ssar_rcv (.clk(clk), .nrst(nrst),
        .link(link_if.rcv), .hw_mode(hw_mode), .hw_mono_sel(hw_mono_sel),
        .cfg_format(rcv_format), .cfg_double_speed(cfg_double_speed), .cfg_word_len(rcv_len),
        .cfg_mono(cfg_mono), .amp_shutdown_n(amp_shutdown_n),
        .soft_clip_select(soft_clip_select), .amp_fault_n(amp_fault_n),
        .clip_enable(clip_enable), .mono_active(mono_active),
        .double_speed_active(double_speed_active), .overrun(overrun), .pair_valid(rcv_valid),
        .pair_ready(rcv_ready), .pair_left(rcv_left), .pair_right(rcv_right));

    ssar_link_sva #(.HALF_CYC(BCLK_HALF_CYC)) i_ssar_link_sva (.clk(clk), .nrst(nrst),
        .bit_clk(link_if.bit_clk), .frame_select(link_if.frame_select),
        .serial_data(link_if.serial_data), .cfg_format(src_format),
        .cfg_slot_sel(cfg_slot_sel), .cfg_word_len(src_len));

    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Comparison and verdict
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Delivered pairs against the model, and random receive stalls
    // Ready is chosen first, so the pair checked is the one popped at the next rise
    always @(negedge clk) begin
        rcv_ready = !stall_all && ($random(seed) % 4 != 0);
        if (nrst && rcv_valid === 1'b1 && rcv_ready && (rcv_left | rcv_right) != 24'h000000) begin
            if (exp_l.size() == 0) begin
                chk("spare_pair", rcv_left, 24'h000000);
            end else begin
                chk("left", rcv_left, exp_l.pop_front());
                chk("right", rcv_right, exp_r.pop_front());
            end
        end
    end

    // Feeds random words to the source back to back and builds the expected pairs
    task automatic send_pairs(input int cnt);
        logic [OUT_W-1:0] l, r, m;
        logic mono;
        int s, n;
        m = ~(24'hFFFFFF >> src_len);
        mono = hw_mode ? hw_mono_sel : cfg_mono;
        for (int i = 0; i < cnt; i++) begin
            l = 24'($random(seed)) & m;
            r = 24'($random(seed)) & m;
            src_left = l;
            src_right = r;
            src_valid = 1'b1;
            s = (int'($signed(l)) + int'($signed(r))) >>> 1;
            exp_l.push_back(mono ? 24'(s) : l);
            exp_r.push_back(mono ? 24'(s) : r);
            n = 0;
            while (src_ready !== 1'b1 && n < 5000) begin
                @(negedge clk);
                n++;
            end
            @(negedge clk);
        end
        src_valid = 1'b0;
    endtask

    // One configuration: reset, settle, traffic, drain and status checks
    task automatic run_case(input int c);
        int fr;
        fr = (16 + 8 * tbl[c][3]) * 32;
        nrst = 1'b0;
        hw_mode = tbl[c][0] != 0;
        hw_mono_sel = tbl[c][5] != 0;
        cfg_mono = hw_mono_sel ^ hw_mode;
        src_format = 2'(tbl[c][1]);
        rcv_format = 2'(tbl[c][2]);
        cfg_slot_sel = 2'(tbl[c][3]);
        src_len = 6'(tbl[c][4]);
        rcv_len = hw_mode ? 6'h10 : src_len;
        cfg_double_speed = tbl[c][6] != 0;
        soft_clip_select = 1'($random(seed));
        repeat (8) @(negedge clk);
        nrst = 1'b1;
        repeat (3 * fr) @(negedge clk);
        send_pairs(5);
        repeat (4 * fr) @(negedge clk);
        chk("pending", exp_l.size(), 0);
        chk("mono", mono_active, hw_mono_sel);
        chk("double", double_speed_active, cfg_double_speed & !hw_mode);
        chk("clip", clip_enable, soft_clip_select);
        chk("fault_n", amp_fault_n, 1'b1);
        chk("overrun", overrun, 1'b0);
    endtask

    // Main sequence
    initial begin
        seed = 32'he174;
        errors = 0;
        num_checks = 0;
        stall_all = 1'b0;
        src_valid = 1'b0;
        src_left = 24'h000000;
        src_right = 24'h000000;
        amp_shutdown_n = 1'b1;
        for (int c = 0; c < 6; c++) begin
            run_case(c);
        end
        stall_all = 1'b1;
        repeat (4000) @(negedge clk);
        chk("stalled_valid", rcv_valid, 1'b1);
        chk("overrun_set", overrun, 1'b1);
        amp_shutdown_n = 1'b0;
        repeat (10) @(negedge clk);
        chk("overrun_clear", overrun, 1'b0);
        chk("fault_idle", amp_fault_n, 1'b1);
        test_done();
    end

    // Watchdog against a hang
    initial begin
        #1000000;
        errors++;
        $display("MISMATCH watchdog expected finish seen hang");
        test_done();
    end
endmodule
`default_nettype wire
